// File: eppv_pkg.sv
// Purpose: shared constants for the code memory program and verify port
// Assumes: mode pins sampled as logic levels; supply level arrives as a digital flag
// Notes: code memory size is a parameter of the top module; encryption table size is fixed here by ENC_AW
package eppv_pkg;

  // ---------------------------------------------------------------
  // mode decode patterns, bit order {a,b,c,d,e}
  // ---------------------------------------------------------------
  localparam logic [4:0] MODE_PROG_CODE = 5'h0f;
  localparam logic [4:0] MODE_VERIFY = 5'h03;
  localparam logic [4:0] MODE_PROG_ENC = 5'h0d;
  localparam logic [4:0] MODE_LOCK_ONE = 5'h1f;
  localparam logic [4:0] MODE_LOCK_TWO = 5'h1c;
  localparam logic [4:0] MODE_LOCK_THREE = 5'h16;
  localparam logic [4:0] MODE_SIGNATURE = 5'h00;

  // ---------------------------------------------------------------
  // widths, reset values, signature map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int ENC_AW = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] SIG_ADDR_0 = 8'h30;
  localparam logic [7:0] SIG_ADDR_1 = 8'h31;
  localparam logic [7:0] SIG_ADDR_2 = 8'h60;

  typedef enum logic [7:0] {
    EPPV_IDLE = 8'h01,
    EPPV_PROG_CODE = 8'h02,
    EPPV_PROG_ENC = 8'h04,
    EPPV_LOCK_ONE = 8'h08,
    EPPV_LOCK_TWO = 8'h10,
    EPPV_LOCK_THREE = 8'h20,
    EPPV_VERIFY = 8'h40,
    EPPV_SIGNATURE = 8'h80
  } eppv_mode_e;

endpackage : eppv_pkg

// File: eppv_sync.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: each bit is an independent slow level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module eppv_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : eppv_sync

// File: eppv_port.sv
// Purpose: program and verify port of the on-chip code memory
// Assumes: prog_supply_high flags the raised programming supply; strobe and mode pins are asynchronous
// Notes: memory is flip-flops, so CODE_AW is kept small by default for simulation
`timescale 1ns/1ps
// Operation
// - the address comes from port one (low byte) and the five low pins of port two (upper bits).
// - a byte is written only on a low strobe pulse while a program mode is selected.
// - program code mode is reset high, store low, supply raised, a low and b to e high.
// - verify mode is reset high, store low, strobe and supply at logic high, a b c low, d e high.
// - encryption, three lock bits and signature read each have their own fixed mode pin pattern.
// - lock bits cannot be read over port zero, only seen on the lock_bit_one to lock_bit_three outputs and through the protection of one and two.
// - verify output is the code byte xnor the encryption byte chosen by six address lines.
module eppv_port #(
  parameter int CODE_AW = 8,
  parameter logic [7:0] SIG_BYTE_0 = 8'h11, // arbitrary value
  parameter logic [7:0] SIG_BYTE_1 = 8'h22, // arbitrary value
  parameter logic [7:0] SIG_BYTE_2 = 8'h33 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_pin,
  input wire logic program_store_enable_n,
  input wire logic latch_program_strobe,
  input wire logic ext_access_prog_supply,
  input wire logic prog_supply_high,
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic mode_pin_c,
  input wire logic mode_pin_d,
  input wire logic mode_pin_e,
  input wire logic [7:0] port1_in,
  input wire logic [4:0] port2_addr_in,
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic lock_bit_one,
  output logic lock_bit_two,
  output logic lock_bit_three
);

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  localparam int PIN_W = 1 + 1 + 1 + 1 + 1 + 5 + 8 + 5 + 8;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  assign pins_raw = {rst_pin, program_store_enable_n, latch_program_strobe, ext_access_prog_supply,
                     prog_supply_high, mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e,
                     port2_addr_in, port1_in, port0_in};

  // idle strobe and store pins are high
  eppv_sync #(.W(PIN_W), .INIT({2'b01, 1'b1, {(PIN_W-3){1'b0}}})) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pins_raw),
    .dout(pins_s)
  );

  logic s_rst;
  logic s_store_n;
  logic s_strobe;
  logic s_ea;
  logic s_vpp;
  logic [4:0] s_mode;
  logic [12:0] s_addr;
  logic [7:0] s_data;
  assign {s_rst, s_store_n, s_strobe, s_ea, s_vpp, s_mode, s_addr, s_data} = pins_s;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  eppv_pkg::eppv_mode_e mode;
  logic base_ok;
  always_comb begin
    base_ok = s_rst && !s_store_n;
    mode = eppv_pkg::EPPV_IDLE;
    if (base_ok && s_vpp) begin
      case (s_mode)
        eppv_pkg::MODE_PROG_CODE: mode = eppv_pkg::EPPV_PROG_CODE;
        eppv_pkg::MODE_PROG_ENC: mode = eppv_pkg::EPPV_PROG_ENC;
        eppv_pkg::MODE_LOCK_ONE: mode = eppv_pkg::EPPV_LOCK_ONE;
        eppv_pkg::MODE_LOCK_TWO: mode = eppv_pkg::EPPV_LOCK_TWO;
        eppv_pkg::MODE_LOCK_THREE: mode = eppv_pkg::EPPV_LOCK_THREE;
        default: mode = eppv_pkg::EPPV_IDLE;
      endcase
    end else if (base_ok && s_ea && s_strobe) begin
      // supply must be at logic level, not raised, for reads
      case (s_mode)
        eppv_pkg::MODE_VERIFY: mode = eppv_pkg::EPPV_VERIFY;
        eppv_pkg::MODE_SIGNATURE: mode = eppv_pkg::EPPV_SIGNATURE;
        default: mode = eppv_pkg::EPPV_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // strobe edge and write
  // ---------------------------------------------------------------
  logic strobe_q;
  logic strobe_d;
  logic fall;
  logic [CODE_AW-1:0] waddr;
  logic [eppv_pkg::ENC_AW-1:0] eaddr;
  logic prog_mode;
  assign fall = strobe_q && !s_strobe;
  assign waddr = s_addr[CODE_AW-1:0];
  assign eaddr = s_addr[eppv_pkg::ENC_AW-1:0];
  // strobe pin only drops low in program modes once supply is raised
  assign prog_mode = s_vpp && (mode != eppv_pkg::EPPV_IDLE) && (mode != eppv_pkg::EPPV_VERIFY)
                     && (mode != eppv_pkg::EPPV_SIGNATURE);

  logic [7:0] code_q [2**CODE_AW];
  logic [7:0] code_d [2**CODE_AW];
  logic [7:0] enc_q [2**eppv_pkg::ENC_AW];
  logic [7:0] enc_d [2**eppv_pkg::ENC_AW];
  logic [2:0] lock_q;
  logic [2:0] lock_d;
  logic locked;
  // eprom cells only clear bits; repeated pulses are harmless
  assign locked = lock_q[0];

  // decode as the strobe falls, while mode pins still stand
  logic [4:0] mode_at;
  assign mode_at = s_mode;

  always_comb begin
    strobe_d = s_strobe;
    lock_d = lock_q;
    if (fall && prog_mode && !locked) begin
      if (mode_at == eppv_pkg::MODE_LOCK_ONE) lock_d[0] = 1'b1;
      if (mode_at == eppv_pkg::MODE_LOCK_TWO) lock_d[1] = 1'b1;
      if (mode_at == eppv_pkg::MODE_LOCK_THREE) lock_d[2] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2**CODE_AW; gi++) begin : g_code
      always_comb begin
        code_d[gi] = code_q[gi];
        if (fall && prog_mode && !locked && mode_at == eppv_pkg::MODE_PROG_CODE
            && waddr == CODE_AW'(gi)) begin
          code_d[gi] = code_q[gi] & s_data;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          code_q[gi] <= eppv_pkg::ERASED_BYTE;
        end else begin
          code_q[gi] <= code_d[gi];
        end
      end
    end
    for (gi = 0; gi < 2**eppv_pkg::ENC_AW; gi++) begin : g_enc
      always_comb begin
        enc_d[gi] = enc_q[gi];
        if (fall && prog_mode && !locked && mode_at == eppv_pkg::MODE_PROG_ENC
            && eaddr == (eppv_pkg::ENC_AW)'(gi)) begin
          enc_d[gi] = enc_q[gi] & s_data;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          enc_q[gi] <= eppv_pkg::ERASED_BYTE;
        end else begin
          enc_q[gi] <= enc_d[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic oe_q;
  logic oe_d;
  always_comb begin
    out_d = 8'h00;
    oe_d = 1'b0;
    case (mode)
      eppv_pkg::EPPV_VERIFY: begin
        // lock two blocks verify; the bus then floats
        oe_d = !lock_q[1];
        out_d = ~(code_q[waddr] ^ enc_q[eaddr]);
      end
      eppv_pkg::EPPV_SIGNATURE: begin
        oe_d = 1'b1;
        if (s_addr[7:0] == eppv_pkg::SIG_ADDR_0) out_d = SIG_BYTE_0;
        else if (s_addr[7:0] == eppv_pkg::SIG_ADDR_1) out_d = SIG_BYTE_1;
        else if (s_addr[7:0] == eppv_pkg::SIG_ADDR_2) out_d = SIG_BYTE_2;
        else out_d = eppv_pkg::ERASED_BYTE;
      end
      default: begin
        oe_d = 1'b0;
        out_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strobe_q <= 1'b1;
      lock_q <= 3'h0;
      out_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      lock_q <= lock_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign port0_out = out_q;
  assign port0_oe = oe_q;
  // lock state is a plain status level for the rest of the chip, never read over port zero
  assign lock_bit_one = lock_q[0];
  assign lock_bit_two = lock_q[1];
  assign lock_bit_three = lock_q[2];

endmodule : eppv_port

// File: eppv_port_assertions.sv
// Purpose: pin-level checks on the program and verify port
// Assumes: read output settles three edges after the pins do
// Notes: bound onto every eppv_port instance
`timescale 1ns/1ps
module eppv_chk (
  input wire logic clk_sys, rst, rst_pin, program_store_enable_n, latch_program_strobe,
  input wire logic ext_access_prog_supply, prog_supply_high, port0_oe,
  input wire logic mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e,
  input wire logic [7:0] port0_out,
  input wire logic lock_bit_one, lock_bit_two, lock_bit_three
);
  wire logic [4:0] m = {mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e};
  wire logic rd_ok = rst_pin && !program_store_enable_n && latch_program_strobe
    && ext_access_prog_supply && !prog_supply_high;
  wire logic ver = rd_ok && m == eppv_pkg::MODE_VERIFY;
  wire logic sig = rd_ok && m == eppv_pkg::MODE_SIGNATURE;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !port0_oe && port0_out == 8'h00
    && !lock_bit_one && !lock_bit_two && !lock_bit_three) else $error("outputs not cleared by reset");
  verify_drive_a: assert property (ver [*3] |=> port0_oe == !lock_bit_two) else $error("verify drive wrong");
  sig_drive_a: assert property (sig [*3] |=> port0_oe) else $error("signature not driven");
  no_drive_a: assert property (!(ver || sig) [*3] |=> !port0_oe) else $error("port zero not released");
  lock_hold_a: assert property (!($fell(lock_bit_one) || $fell(lock_bit_two) || $fell(lock_bit_three)))
    else $error("lock bit cleared without reset");
  lock1_cause_a: assert property ($rose(lock_bit_one) |-> $past(m, 3) == eppv_pkg::MODE_LOCK_ONE
    && $past(prog_supply_high, 3)) else $error("lock one set without its mode");
  lock2_cause_a: assert property ($rose(lock_bit_two) |-> $past(m, 3) == eppv_pkg::MODE_LOCK_TWO
    && $past(prog_supply_high, 3)) else $error("lock two set without its mode");
  lock3_cause_a: assert property ($rose(lock_bit_three) |-> $past(m, 3) == eppv_pkg::MODE_LOCK_THREE
    && $past(prog_supply_high, 3)) else $error("lock three set without its mode");
endmodule : eppv_chk
bind eppv_port eppv_chk chk_u (.*);

// File: eppv_prog_model.sv
// Purpose: behavioural programmer driving the device pins
// Assumes: pins change at the falling clock edge
// Notes: supply raise is the digital flag; data is inverted when released
`timescale 1ns/1ps
module eppv_prog_model (
  input wire logic clk_sys,
  output logic rst_pin, program_store_enable_n, latch_program_strobe, ext_access_prog_supply,
  output logic prog_supply_high, mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e,
  output logic [7:0] port1_in, port0_drv,
  output logic [4:0] port2_addr_in
);
  initial begin
    {rst_pin, program_store_enable_n, latch_program_strobe, ext_access_prog_supply} = 4'hb;
    prog_supply_high = 1'b0;
    {mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e} = eppv_pkg::MODE_VERIFY;
    {port2_addr_in, port1_in} = 13'h0000;
    port0_drv = 8'h00;
  end
  task automatic setp(input logic [4:0] m, input logic [12:0] adr);
    {mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e} = m;
    {port2_addr_in, port1_in} = adr;
    prog_supply_high = 1'b0;
  endtask : setp
  task automatic prog(input logic [4:0] m, input logic [12:0] adr, input logic [7:0] d, input int n);
    @(negedge clk_sys);
    setp(m, adr);
    port0_drv = d;
    repeat (2) @(negedge clk_sys);
    prog_supply_high = 1'b1;
    repeat (4) @(negedge clk_sys);
    repeat (n) begin
      latch_program_strobe = 1'b0;
      repeat (3) @(negedge clk_sys);
      latch_program_strobe = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
    prog_supply_high = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : prog
  task automatic rd(input logic [4:0] m, input logic [12:0] adr);
    @(negedge clk_sys);
    setp(m, adr);
    port0_drv = ~port0_drv;
    repeat (4) @(negedge clk_sys);
  endtask : rd
endmodule : eppv_prog_model

// File: tb_eprom_program_verify_port.sv
// Purpose: self-checking bench for the program and verify port
// Assumes: default memory size and signature values
// Notes: shadow arrays model the cells, erased on every reset
`timescale 1ns/1ps
module tb_eprom_program_verify_port;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rst_pin, program_store_enable_n, latch_program_strobe, ext_access_prog_supply, prog_supply_high;
  logic mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d, mode_pin_e, port0_oe, lk1;
  logic lock_bit_one, lock_bit_two, lock_bit_three;
  logic [7:0] port1_in, port0_drv, port0_out, d;
  logic [7:0] mem [256];
  logic [7:0] enc [64];
  logic [4:0] port2_addr_in;
  logic [12:0] a;
  int n_fail = 0;
  int check_count = 0;
  // the wire shows the device whenever it drives
  wire logic [7:0] port0_in = port0_oe ? port0_out : port0_drv;
  // clock never stops during a session, the transfers depend on it
  initial forever #10 clk_sys = ~clk_sys;
  eppv_prog_model pm_u (.*);
  eppv_port dut_u (.*);
  function automatic logic [7:0] vexp(input logic [12:0] x);
    return ~(mem[x[7:0]] ^ enc[x[5:0]]);
  endfunction : vexp
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic erase;
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (enc[i]) enc[i] = 8'hff;
    lk1 = 1'b0;
  endtask : erase
  task automatic do_rst;
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    erase();
    chk("locks", {5'h00, lock_bit_one, lock_bit_two, lock_bit_three}, 8'h00);
  endtask : do_rst
  task automatic pw(input logic [4:0] m, input logic [12:0] x, input logic [7:0] v, input int n);
    pm_u.prog(m, x, v, n);
    // cells only clear bits, and nothing lands once lock one is set
    if (m == eppv_pkg::MODE_PROG_CODE && !lk1) mem[x[7:0]] &= v;
    if (m == eppv_pkg::MODE_PROG_ENC && !lk1) enc[x[5:0]] &= v;
  endtask : pw
  task automatic rdv(input logic [4:0] m, input logic [12:0] x, input logic [7:0] e, input logic oe);
    pm_u.rd(m, x);
    chk("port0_oe", {7'h00, port0_oe}, {7'h00, oe});
    if (oe) chk("port0_out", port0_out, e);
  endtask : rdv
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hfa35c926));
    erase();
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    rdv(eppv_pkg::MODE_VERIFY, 13'h1abc, 8'hff, 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i % 2 == 0) a = 13'($urandom);
      d = 8'($urandom);
      pw(eppv_pkg::MODE_PROG_CODE, a, d, 5);
      rdv(eppv_pkg::MODE_VERIFY, a, vexp(a), 1'b1);
    end
    pw(5'h0e, a, 8'h00, 5);
    rdv(eppv_pkg::MODE_VERIFY, a, vexp(a), 1'b1);
    pw(eppv_pkg::MODE_PROG_ENC, a, 8'($urandom), 25);
    rdv(eppv_pkg::MODE_VERIFY, a, vexp(a), 1'b1);
    rdv(eppv_pkg::MODE_VERIFY, a ^ 13'h0040, vexp(a ^ 13'h0040), 1'b1);
    rdv(eppv_pkg::MODE_SIGNATURE, 13'h0030, 8'h11, 1'b1);
    rdv(eppv_pkg::MODE_SIGNATURE, 13'h0031, 8'h22, 1'b1);
    rdv(eppv_pkg::MODE_SIGNATURE, 13'h0060, 8'h33, 1'b1);
    rdv(eppv_pkg::MODE_SIGNATURE, 13'h0032, 8'hff, 1'b1);
    rdv(5'h15, a, 8'h00, 1'b0);
    pw(eppv_pkg::MODE_LOCK_THREE, a, 8'h00, 25);
    chk("lock_three", {7'h00, lock_bit_three}, 8'h01);
    pw(eppv_pkg::MODE_LOCK_ONE, a, 8'h00, 25);
    lk1 = 1'b1;
    chk("lock_one", {7'h00, lock_bit_one}, 8'h01);
    pw(eppv_pkg::MODE_PROG_CODE, a, 8'h00, 5);
    rdv(eppv_pkg::MODE_VERIFY, a, vexp(a), 1'b1);
    do_rst();
    pw(eppv_pkg::MODE_LOCK_TWO, a, 8'h00, 25);
    chk("lock_two", {7'h00, lock_bit_two}, 8'h01);
    rdv(eppv_pkg::MODE_VERIFY, a, 8'h00, 1'b0);
    do_rst();
    rdv(eppv_pkg::MODE_VERIFY, a, 8'hff, 1'b1);
    report_and_stop();
  end
endmodule : tb_eprom_program_verify_port
